// [hw/pss_buf_if.sv]
// valid/ready carrier between the port logic and the write buffer
// assumes one clock domain
interface pss_buf_if #(
    parameter int W = 8
);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport buf_side (
        input  in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport user_side (
        output in_valid, in_data, out_ready,
        input  in_ready, out_valid, out_data
    );
endinterface : pss_buf_if

// [hw/pss_data_port.sv]
// data port of a pipelined synchronous sram: input register, one-cycle
// registered read pipeline, output enable control and burst counter
// assumes the bus master drives i_clk; output enable and burst-order strap
// are asynchronous to it; the tristate wire is resolved outside from *_oe
`include "pss_params.svh"

module pss_data_port
    import pss_pkg::*;
#(
    parameter int DATA_W = `PSS_DATA_W,
    parameter int PAR_W  = `PSS_PAR_W,
    parameter int ADDR_W = `PSS_ADDR_W
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_sys_rst,
    // access control, synchronous to i_clk
    input  wire logic              i_addr_strobe_n,
    input  wire logic              i_chip_sel,
    input  wire logic              i_global_write_n,
    input  wire logic              i_burst_step_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    // asynchronous controls
    input  wire logic              i_out_en_n,
    input  wire logic              i_burst_order,
    // data and parity pins
    input  wire logic [DATA_W-1:0] i_data_in,
    output logic      [DATA_W-1:0] o_data_out,
    output logic                   o_data_oe,
    input  wire logic [PAR_W-1:0]  i_parity_lines_in,
    output logic      [PAR_W-1:0]  o_parity_lines_out,
    output logic                   o_parity_lines_oe,
    // write path status
    output logic                   o_wr_ready
);
    localparam int WW = DATA_W + PAR_W;
    localparam int BW = ADDR_W + WW;
    localparam int DEPTH = 1 << ADDR_W;

    // ==========================================
    // asynchronous input synchronisers
    logic       oe_n_s1_r;
    logic       oe_n_s2_r;
    logic       ord_s1_r;
    logic       ord_s2_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            oe_n_s1_r <= 1'b1;
            oe_n_s2_r <= 1'b1;
            ord_s1_r  <= 1'b1;
            ord_s2_r  <= 1'b1;
        end else begin
            oe_n_s1_r <= i_out_en_n;
            oe_n_s2_r <= oe_n_s1_r;
            ord_s1_r  <= i_burst_order;
            ord_s2_r  <= ord_s1_r;
        end
    end

    // ==========================================
    // access state and burst counter
    pss_state_type     st_r;
    pss_state_type     st_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    pss_low_type       cnt_r;
    pss_low_type       cnt_nxt;
    logic              first_r;
    logic              first_nxt;
    logic              order_r;
    logic              order_nxt;
    logic              strobe;
    logic              wr_start;
    logic [ADDR_W-1:0] cur_addr;

    always_comb begin
        strobe    = !i_addr_strobe_n;
        wr_start  = strobe && i_chip_sel && !i_global_write_n;
        st_nxt    = st_r;
        addr_nxt  = addr_r;
        cnt_nxt   = cnt_r;
        first_nxt = 1'b0;
        order_nxt = ord_s2_r;
        if (strobe) begin
            if (i_chip_sel) begin
                addr_nxt  = i_addr;
                cnt_nxt   = `PSS_CNT_ZERO;
                st_nxt    = i_global_write_n ? PSS_READ : PSS_WRITE;
                first_nxt = (st_r == PSS_IDLE);
            end else begin
                st_nxt = PSS_IDLE;
            end
        end else if (!i_burst_step_n && (st_r != PSS_IDLE)) begin
            cnt_nxt = pss_low_type'(cnt_r + `PSS_CNT_ONE);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_r    <= PSS_IDLE;
            addr_r  <= '0;
            cnt_r   <= `PSS_CNT_ZERO;
            first_r <= 1'b0;
            order_r <= 1'b1;
        end else begin
            st_r    <= st_nxt;
            addr_r  <= addr_nxt;
            cnt_r   <= cnt_nxt;
            first_r <= first_nxt;
            order_r <= order_nxt;
        end
    end

    // interleaved: start xor count; linear: start plus count mod four
    assign cur_addr = {addr_r[ADDR_W-1:`PSS_CNT_W],
                       pss_burst_addr(addr_r[`PSS_CNT_W-1:0], cnt_r, order_r)};

    // ==========================================
    // input register and write capture
    logic [WW-1:0]     din_r;
    logic [WW-1:0]     din_nxt;
    logic              push_v_r;
    logic              push_v_nxt;
    logic [ADDR_W-1:0] push_a_r;
    logic [ADDR_W-1:0] push_a_nxt;

    pss_buf_if #(.W(BW)) wbuf ();

    always_comb begin
        din_nxt    = {i_parity_lines_in, i_data_in};
        push_v_nxt = push_v_r;
        push_a_nxt = push_a_r;
        if (push_v_r && !wbuf.in_ready) begin
            din_nxt = din_r;
        end else begin
            push_v_nxt = (st_r == PSS_WRITE);
            push_a_nxt = cur_addr;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            din_r    <= '0;
            push_v_r <= 1'b0;
            push_a_r <= '0;
        end else begin
            din_r    <= din_nxt;
            push_v_r <= push_v_nxt;
            push_a_r <= push_a_nxt;
        end
    end

    assign wbuf.in_valid  = push_v_r;
    assign wbuf.in_data   = {push_a_r, din_r};
    // reads own the array; buffered writes drain in other cycles
    assign wbuf.out_ready = (st_r != PSS_READ);

    pss_skid_buf #(
        .W     (BW),
        .DEPTH (`PSS_BUF_DEPTH)
    ) u_wbuf (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .bus       (wbuf)
    );

    // ==========================================
    // array and registered read pipeline
    logic [WW-1:0] mem_r [DEPTH];
    logic [WW-1:0] rd_r;
    logic [WW-1:0] rd_nxt;
    logic          oe_r;
    logic          oe_nxt;
    logic          wr_rdy_r;
    logic          drain;

    always_comb begin
        drain  = wbuf.out_valid && wbuf.out_ready;
        rd_nxt = rd_r;
        if (st_r == PSS_READ) begin
            rd_nxt = mem_r[cur_addr];
        end
        oe_nxt = (st_r == PSS_READ) && !oe_n_s2_r;
        if (first_r) begin
            oe_nxt = 1'b0;
        end
        if (wr_start || (st_r == PSS_WRITE)) begin
            oe_nxt = 1'b0;
        end
        if (strobe && !i_chip_sel) begin
            oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rd_r     <= '0;
            oe_r     <= 1'b0;
            wr_rdy_r <= 1'b1;
        end else begin
            rd_r     <= rd_nxt;
            oe_r     <= oe_nxt;
            wr_rdy_r <= wbuf.in_ready;
        end
        if (drain) begin
            mem_r[wbuf.out_data[BW-1:WW]] <= wbuf.out_data[WW-1:0];
        end
    end

    // ==========================================
    // pin outputs
    assign o_data_out         = rd_r[DATA_W-1:0];
    assign o_parity_lines_out = rd_r[WW-1:DATA_W];
    assign o_data_oe          = oe_r;
    assign o_parity_lines_oe  = oe_r;
    assign o_wr_ready         = wr_rdy_r;

endmodule : pss_data_port

// [hw/pss_params.svh]
// constants for the pipelined sram data port
// assumes inclusion by the package and the design modules only
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ==========================================
// widths and write buffer depth
`define PSS_DATA_W      32
`define PSS_PAR_W       4
`define PSS_ADDR_W      4
`define PSS_CNT_W       2
`define PSS_BUF_DEPTH   2

// ==========================================
// reset values and counter constants
`define PSS_CNT_ZERO    2'h0
`define PSS_CNT_ONE     2'h1
`define PSS_LVL_COUNT   2'h2

`endif

// [hw/pss_pkg.sv]
// types shared by the data port modules
// assumes pss_params.svh is on the include path
`include "pss_params.svh"

package pss_pkg;

    // ==========================================
    // access state
    typedef enum logic [1:0] {
        PSS_IDLE  = 2'b00,
        PSS_READ  = 2'b01,
        PSS_WRITE = 2'b10
    } pss_state_type;

    typedef logic [`PSS_CNT_W-1:0] pss_low_type;

    // ==========================================
    // burst sequence: interleaved xors the count in, linear adds it
    function automatic pss_low_type pss_burst_addr(input pss_low_type start,
                                                   input pss_low_type cnt,
                                                   input logic        interleave);
        pss_burst_addr = interleave ? (start ^ cnt) : pss_low_type'(start + cnt);
    endfunction : pss_burst_addr

endpackage : pss_pkg

// [hw/pss_skid_buf.sv]
// two-entry valid/ready buffer for captured write words
// assumes synchronous active-high reset on the shared clock
`include "pss_params.svh"

module pss_skid_buf
    import pss_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = `PSS_BUF_DEPTH
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // carrier
    pss_buf_if.buf_side bus
);
    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [IW:0] FULL = (IW+1)'(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [IW-1:0] wp_r;
    logic [IW-1:0] wp_nxt;
    logic [IW-1:0] rp_r;
    logic [IW-1:0] rp_nxt;
    logic [IW:0]   cnt_r;
    logic [IW:0]   cnt_nxt;
    logic          rdy_r;
    logic          rdy_nxt;
    logic          push;
    logic          pop;

    function automatic logic [IW-1:0] bump(input logic [IW-1:0] p);
        bump = (p == IW'(DEPTH - 1)) ? '0 : IW'(p + 1'b1);
    endfunction : bump

    // ==========================================
    // next state
    always_comb begin
        push    = bus.in_valid && rdy_r;
        pop     = bus.out_ready && (cnt_r != '0);
        wp_nxt  = push ? bump(wp_r) : wp_r;
        rp_nxt  = pop ? bump(rp_r) : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = (IW+1)'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = (IW+1)'(cnt_r - 1'b1);
        end
        rdy_nxt = (cnt_nxt != FULL);
    end

    // ==========================================
    // registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= bus.in_data;
        end
    end

    assign bus.in_ready  = rdy_r;
    assign bus.out_valid = (cnt_r != '0);
    assign bus.out_data  = mem_r[rp_r];

endmodule : pss_skid_buf

// [tb/pss_bus_model.sv]
// bus master side of the data and parity pins with wire resolution
// assumes the master drives only while the device output enable is low
module pss_bus_model (
    // clock
    input  wire logic        i_clk,
    // master side
    input  wire logic        i_drv,
    input  wire logic [35:0] i_drv_val,
    // device side
    input  wire logic        i_dev_oe,
    input  wire logic [35:0] i_dev_val,
    // resolved pins
    output logic      [35:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] last_r;
    // undriven pins show a changing pattern, never the old value
    always @(posedge i_clk) last_r <= o_pins;
    assign o_pins = i_drv ? i_drv_val : i_dev_oe ? i_dev_val : ~last_r;
endmodule : pss_bus_model

// [tb/pss_data_port_monitor.sv]
// checker for the data port, bound to its top module
// assumes one clock domain and a synchronous active-high reset
module pss_data_port_monitor #(
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic              i_clk,
    input wire logic              i_sys_rst,
    // access control
    input wire logic              i_addr_strobe_n,
    input wire logic              i_chip_sel,
    input wire logic              i_global_write_n,
    input wire logic              i_burst_step_n,
    // output enable
    input wire logic              i_out_en_n,
    // pin outputs
    input wire logic [DATA_W-1:0] o_data_out,
    input wire logic              o_data_oe,
    input wire logic              o_parity_lines_oe,
    input wire logic              o_wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // ==========================================
    // properties
    property p_oe_pair;
        o_data_oe == o_parity_lines_oe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("oe pair differ");
    property p_oe_off;
        i_out_en_n [*5] |-> !o_data_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("drive while disabled");
    property p_wr_tri;
        !i_addr_strobe_n && i_chip_sel && !i_global_write_n |=> !o_data_oe;
    endproperty
    a_wr_tri: assert property (p_wr_tri) else $error("drive on write");
    property p_wr_hold;
        (!i_addr_strobe_n && i_chip_sel && !i_global_write_n) ##1 i_addr_strobe_n [*2]
            |=> !o_data_oe;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("drive in write");
    property p_desel;
        !i_addr_strobe_n && !i_chip_sel |-> ##[1:2] !o_data_oe;
    endproperty
    a_desel: assert property (p_desel) else $error("drive after deselect");
    property p_first;
        (!i_addr_strobe_n && !i_chip_sel) ##1 (!i_addr_strobe_n && i_chip_sel
            && i_global_write_n) |=> !o_data_oe ##1 !o_data_oe;
    endproperty
    a_first: assert property (p_first) else $error("first read cycle driven");
    property p_hold;
        $past(i_addr_strobe_n) && $past(i_burst_step_n) && i_addr_strobe_n
            && i_burst_step_n |=> $stable(o_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst;
        $fell(i_sys_rst) |-> !o_data_oe && o_data_out == '0 && o_wr_ready;
    endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
endmodule : pss_data_port_monitor

// [tb/tb_pipelined_sram_data_port.sv]
// self-checking bench for the data port
// assumes the checker and bus model files are compiled first
module tb_pipelined_sram_data_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 0, i_sys_rst = 1, stb_n = 1, cs = 0, wrt_n = 1;
    logic        step_n = 1, oe_n = 0, order = 1, drv = 0, d_oe, p_oe, wr_rdy;
    logic [3:0]  addr = 4'h0, p_out;
    logic [31:0] d_out;
    logic [35:0] drv_val = 36'h0, pins, mem [16];
    int          n_fail = 0, n_checks = 0;
    pss_data_port u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr_strobe_n(stb_n),
        .i_chip_sel(cs), .i_global_write_n(wrt_n), .i_burst_step_n(step_n), .i_addr(addr),
        .i_out_en_n(oe_n), .i_burst_order(order), .i_data_in(pins[31:0]),
        .o_data_out(d_out), .o_data_oe(d_oe), .i_parity_lines_in(pins[35:32]),
        .o_parity_lines_out(p_out), .o_parity_lines_oe(p_oe), .o_wr_ready(wr_rdy));
    pss_bus_model u_bus (.i_clk(i_clk), .i_drv(drv), .i_drv_val(drv_val), .i_dev_oe(d_oe),
        .i_dev_val({p_out, d_out}), .o_pins(pins));
    initial forever #2 i_clk = ~i_clk;
    // ==========================================
    // helpers
    task chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    function automatic logic [3:0] beat_addr(input logic [3:0] s, input logic [1:0] i);
        beat_addr = {s[3:2], order ? s[1:0] ^ i : 2'(s[1:0] + i)};
    endfunction : beat_addr
    task wr_burst(input logic [3:0] a, input logic [35:0] base);
        @(posedge i_clk);
        {stb_n, cs, wrt_n, addr} <= {1'b0, 1'b1, 1'b0, a};
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            {stb_n, drv, drv_val} <= {1'b1, 1'b1, base + 36'(i)};
            step_n <= (i < 3) ? 1'b0 : 1'b1;
            mem[beat_addr(a, 2'(i))] = base + 36'(i);
            #1 chk("oe in write", 36'h0, 36'(d_oe));
            chk("write ready", 36'h1, 36'(wr_rdy));
        end
        @(posedge i_clk);
        {stb_n, cs} <= 2'b00;
        @(posedge i_clk);
        {stb_n, drv, wrt_n} <= 3'b101;
        repeat (4) @(posedge i_clk);
    endtask : wr_burst
    task rd_burst(input logic [3:0] a, input logic oen);
        // every read opens straight out of a deselect cycle
        @(posedge i_clk);
        {stb_n, cs} <= 2'b00;
        @(posedge i_clk);
        {stb_n, cs, wrt_n, addr} <= {1'b0, 1'b1, 1'b1, a};
        @(posedge i_clk);
        {stb_n, step_n} <= 2'b10;
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            step_n <= (i < 2) ? 1'b0 : 1'b1;
            #1 chk("read word", mem[beat_addr(a, 2'(i))], {p_out, d_out});
            chk("read oe", 36'(i > 0 && !oen), 36'(d_oe));
            chk("parity oe", 36'(i > 0 && !oen), 36'(p_oe));
        end
        @(posedge i_clk);
        {stb_n, cs} <= 2'b00;
        #1 chk("read hold", mem[beat_addr(a, 2'h3)], {p_out, d_out});
        @(posedge i_clk);
        stb_n <= 1'b1;
        #1 chk("oe deselect", 36'h0, 36'(d_oe));
    endtask : rd_burst
    // ==========================================
    // scenarios
    task t_interleaved;
        order <= 1'b1;
        repeat (4) @(posedge i_clk);
        wr_burst(4'h0, 36'hA_1234_5670);
        rd_burst(4'h1, 1'b0);
    endtask : t_interleaved
    task t_linear;
        @(posedge i_clk);
        order <= 1'b0;
        repeat (4) @(posedge i_clk);
        wr_burst(4'h6, 36'h5_CAFE_0010);
        rd_burst(4'h5, 1'b0);
    endtask : t_linear
    task t_oe_off;
        @(posedge i_clk);
        oe_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        rd_burst(4'h2, 1'b1);
        @(posedge i_clk);
        oe_n <= 1'b0;
    endtask : t_oe_off
    task final_report;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        t_interleaved();
        t_linear();
        t_oe_off();
        final_report();
    end
    initial begin
        #20000;
        n_fail++;
        final_report();
    end
endmodule : tb_pipelined_sram_data_port
bind pss_data_port pss_data_port_monitor #(.DATA_W(DATA_W)) u_mon (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_addr_strobe_n(i_addr_strobe_n), .i_chip_sel(i_chip_sel),
    .i_global_write_n(i_global_write_n), .i_burst_step_n(i_burst_step_n),
    .i_out_en_n(i_out_en_n), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
    .o_parity_lines_oe(o_parity_lines_oe), .o_wr_ready(o_wr_ready));
